/* File: hw/wcab_pkg.sv */
// Package: constants, register map and carrier types of the window comparator
package wcab_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int SAMPLE_W  = 12;
    localparam int CHANNELS  = 2;
    localparam int BUF_DEPTH = 16;
    localparam int LIMIT_W   = 4;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_LOW_FLAGS  = 8'h04;
    localparam logic [7:0] OFF_HIGH_FLAGS = 8'h08;
    localparam logic [7:0] OFF_TRIG_CHAN  = 8'h0c;
    localparam logic [7:0] OFF_STATUS     = 8'h10;
    localparam logic [7:0] OFF_THR_BASE   = 8'h20;
    localparam logic [7:0] OFF_THR_LAST   = 8'h3c;
    localparam logic [7:0] OFF_BUF_BASE   = 8'h40;
    localparam logic [7:0] OFF_BUF_LAST   = 8'h7c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_MODE_BIT   = 0;
    localparam int CTRL_LIMIT_LSB  = 4;
    localparam int CTRL_LAUNCH_BIT = 8;
    localparam int TRIG_CHAN_LSB   = 4;
    localparam int STAT_CAP_LSB    = 0;
    localparam int STAT_SEEN_BIT   = 2;
    localparam int STAT_ALERT_BIT  = 3;
    localparam int STAT_PTR_LSB    = 8;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [11:0] HIGH_THR_RESET = 12'hfff;
    localparam logic [11:0] LOW_THR_RESET  = 12'h000;
    localparam logic [3:0]  LIMIT_RESET    = 4'h0;
    localparam logic [3:0]  CHAN_ID_0      = 4'h0;
    localparam logic [3:0]  CHAN_ID_1      = 4'h1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        CAP_ARMED = 2'b00,
        CAP_FILL  = 2'b01,
        CAP_DONE  = 2'b11
    } wcab_cap_t;

    typedef enum logic {
        MODE_BEFORE = 1'b0,
        MODE_AFTER  = 1'b1
    } wcab_mode_t;

    typedef struct packed {
        logic                valid;
        logic                chan;
        logic [SAMPLE_W-1:0] data;
    } wcab_sample_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } wcab_apb_req_t;

endpackage

/* File: hw/wcab_event_counter.sv */
// Consecutive-event filter for one comparator of one channel
`timescale 1ns/10ps
module wcab_event_counter #(
    parameter int LIMIT_W = 4
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    input  wire logic               clear,
    input  wire logic               strobe,
    input  wire logic               cond,
    input  wire logic [LIMIT_W-1:0] limit,
    output logic                    hit
);
    typedef struct packed {
        logic [LIMIT_W-1:0] count;
    } wcab_cnt_state_t;

    wcab_cnt_state_t state;
    wcab_cnt_state_t next_state;

    // Count holds earlier consecutive hits, so limit+1 in a row fires
    assign hit = strobe && cond && (state.count >= limit);

    always_comb begin
        next_state = state;
        if (clear) begin
            next_state.count = '0;
        end else if (strobe) begin
            if (!cond) begin
                next_state.count = '0;
            end else if (state.count < limit) begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end
endmodule

/* File: hw/wcab_sample_buffer.sv */
// Sample buffer with one write port and one combinational read port
`timescale 1ns/10ps
module wcab_sample_buffer #(
    parameter int DEPTH  = 16,
    parameter int WIDTH  = 12,
    parameter int ADDR_W = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [WIDTH-1:0]  wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [WIDTH-1:0]  rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } wcab_buf_state_t;

    wcab_buf_state_t state;
    wcab_buf_state_t next_state;

    assign rdata = state.mem[raddr];

    always_comb begin
        next_state = state;
        if (we) begin
            next_state.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end
endmodule

/* File: hw/wcab_top.sv */
// Window comparator with event filter, alert flags and sample buffer
//
// Overview of operation
// - Low comparator: result at or below low threshold
// - High comparator: result at or above high threshold
// - Threshold extremes keep both window edges: full scale and zero still trip
// - Either comparator leaving the window raises alert
// - Alert waits for consecutive asserted conversions
// - Buffer holds sixteen conversion results
// - Before-mode writes buffer continuously, oldest overwritten
// - Before-mode freezes at trigger: 15 plus trigger
// - After-mode starts writing with triggering conversion
// - After-mode stores trigger plus 15, then stops
// - Required count is limit field plus one
// - Latched flags per channel, write one clears
// - Record first alerting channel, cleared by launch
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module wcab_top #(
    parameter int SAMPLE_W  = 12,
    parameter int BUF_DEPTH = 16,
    parameter int LIMIT_W   = 4
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  sample_valid,
    input  wire logic                  sample_chan,
    input  wire logic [SAMPLE_W-1:0]   sample_data,
    output logic                       alert_n_out,
    output logic                       alert_n_oe
);
    localparam int PTR_W = $clog2(BUF_DEPTH);
    localparam int CH    = wcab_pkg::CHANNELS;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [CH-1:0][SAMPLE_W-1:0] hi_thr;
        logic [CH-1:0][SAMPLE_W-1:0] lo_thr;
        logic [LIMIT_W-1:0]          limit;
        wcab_pkg::wcab_mode_t        mode;
        logic [CH-1:0]               low_flag;
        logic [CH-1:0]               high_flag;
        logic [3:0]                  first_trigger_channel;
        logic                        trig_seen;
        wcab_pkg::wcab_cap_t         cap;
        logic [PTR_W-1:0]            ptr;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic                        alert_n_oe;
        logic                        alert_n_out;
    } wcab_state_t;

    wcab_state_t state;
    wcab_state_t next_state;

    wcab_pkg::wcab_sample_t  smp;
    wcab_pkg::wcab_apb_req_t req;

    assign smp = '{valid: sample_valid, chan: sample_chan,
                   data: sample_data};
    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};

    // ****************************************
    // Comparators and event counters
    // ****************************************
    logic [CH-1:0] low_cond;
    logic [CH-1:0] high_cond;
    logic [CH-1:0] low_hit;
    logic [CH-1:0] high_hit;
    logic          launch;
    logic          any_hit;
    logic          trigger;

    genvar gc;
    generate
        for (gc = 0; gc < CH; gc++) begin : g_chan
            // Extreme thresholds need no special case: compares are closed
            assign low_cond[gc]  =
                smp.data <= state.lo_thr[gc];
            assign high_cond[gc] =
                smp.data >= state.hi_thr[gc];

            wcab_event_counter #(
                .LIMIT_W (LIMIT_W)
            ) u_low_cnt (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .clear   (launch),
                .strobe  (smp.valid && (smp.chan == 1'(gc))),
                .cond    (low_cond[gc]),
                .limit   (state.limit),
                .hit     (low_hit[gc])
            );

            wcab_event_counter #(
                .LIMIT_W (LIMIT_W)
            ) u_high_cnt (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .clear   (launch),
                .strobe  (smp.valid && (smp.chan == 1'(gc))),
                .cond    (high_cond[gc]),
                .limit   (state.limit),
                .hit     (high_hit[gc])
            );
        end
    endgenerate

    // Either side of the window counts toward the alert
    assign any_hit = |{low_hit, high_hit};
    assign trigger = any_hit && !state.trig_seen;

    // ****************************************
    // Sample buffer
    // ****************************************
    logic                buf_we;
    logic [PTR_W-1:0]    buf_raddr;
    logic [SAMPLE_W-1:0] buf_rdata;

    wcab_sample_buffer #(
        .DEPTH  (BUF_DEPTH),
        .WIDTH  (SAMPLE_W),
        .ADDR_W (PTR_W)
    ) u_buf (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .we      (buf_we),
        .waddr   (state.ptr),
        .wdata   (smp.data),
        .raddr   (buf_raddr),
        .rdata   (buf_rdata)
    );

    always_comb begin
        buf_we = 1'b0;
        if (smp.valid) begin
            unique case (state.cap)
                wcab_pkg::CAP_ARMED: begin
                    buf_we = (state.mode == wcab_pkg::MODE_BEFORE)
                             || trigger;
                end
                wcab_pkg::CAP_FILL: buf_we = 1'b1;
                default:            buf_we = 1'b0;
            endcase
        end
    end

    // ****************************************
    // APB decode
    // ****************************************
    logic       setup_rd;
    logic       wr_done;
    logic [7:0] off;
    logic [2:0] thr_idx;
    logic       in_thr;
    logic       in_buf;
    logic       mapped;

    assign off      = req.paddr;
    assign setup_rd = req.psel && req.penable && !state.pready;
    assign wr_done  = req.psel && req.penable && state.pready
                      && req.pwrite && !state.pslverr;
    assign thr_idx  = off[4:2];
    assign in_thr   = (off >= wcab_pkg::OFF_THR_BASE)
                      && (off <= wcab_pkg::OFF_THR_LAST);
    assign in_buf   = (off >= wcab_pkg::OFF_BUF_BASE)
                      && (off <= wcab_pkg::OFF_BUF_LAST);
    assign mapped   = (off[1:0] == 2'b00)
                      && ((off <= wcab_pkg::OFF_STATUS) || in_thr
                          || in_buf);
    // Oldest first: after a wrap the pointer marks the oldest
    assign buf_raddr = state.ptr + off[PTR_W+1:2];
    assign launch    = wr_done && (off == wcab_pkg::OFF_CTRL)
                       && req.pwdata[wcab_pkg::CTRL_LAUNCH_BIT];

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_thr) begin
            unique case (thr_idx[1:0])
                2'b00: rd_mux[7:0] = state.hi_thr[thr_idx[2]][7:0];
                2'b01: rd_mux[3:0] = state.hi_thr[thr_idx[2]][11:8];
                2'b10: rd_mux[7:0] = state.lo_thr[thr_idx[2]][7:0];
                2'b11: rd_mux[3:0] = state.lo_thr[thr_idx[2]][11:8];
            endcase
        end else if (in_buf) begin
            rd_mux[SAMPLE_W-1:0] = buf_rdata;
        end else begin
            unique case (off)
                wcab_pkg::OFF_CTRL: begin
                    rd_mux[wcab_pkg::CTRL_MODE_BIT] = state.mode;
                    rd_mux[wcab_pkg::CTRL_LIMIT_LSB +: LIMIT_W] =
                        state.limit;
                end
                wcab_pkg::OFF_LOW_FLAGS:  rd_mux[CH-1:0] = state.low_flag;
                wcab_pkg::OFF_HIGH_FLAGS: rd_mux[CH-1:0] = state.high_flag;
                wcab_pkg::OFF_TRIG_CHAN: begin
                    rd_mux[wcab_pkg::TRIG_CHAN_LSB +: 4] =
                        state.first_trigger_channel;
                end
                wcab_pkg::OFF_STATUS: begin
                    rd_mux[wcab_pkg::STAT_CAP_LSB +: 2] = state.cap;
                    rd_mux[wcab_pkg::STAT_SEEN_BIT]  = state.trig_seen;
                    rd_mux[wcab_pkg::STAT_ALERT_BIT] = state.alert_n_oe;
                    rd_mux[wcab_pkg::STAT_PTR_LSB +: PTR_W] = state.ptr;
                end
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state = state;
        // One wait state: pready rises in the second access cycle
        next_state.pready  = setup_rd;
        next_state.pslverr = setup_rd && !mapped;
        if (setup_rd) begin
            next_state.prdata = mapped ? rd_mux : 32'h0000_0000;
        end

        if (wr_done) begin
            if (in_thr) begin
                unique case (thr_idx[1:0])
                    2'b00: next_state.hi_thr[thr_idx[2]][7:0] =
                        req.pwdata[7:0];
                    2'b01: next_state.hi_thr[thr_idx[2]][11:8] =
                        req.pwdata[3:0];
                    2'b10: next_state.lo_thr[thr_idx[2]][7:0] =
                        req.pwdata[7:0];
                    2'b11: next_state.lo_thr[thr_idx[2]][11:8] =
                        req.pwdata[3:0];
                endcase
            end else if (off == wcab_pkg::OFF_CTRL) begin
                next_state.mode = wcab_pkg::wcab_mode_t'(
                    req.pwdata[wcab_pkg::CTRL_MODE_BIT]);
                next_state.limit =
                    req.pwdata[wcab_pkg::CTRL_LIMIT_LSB +: LIMIT_W];
            end else if (off == wcab_pkg::OFF_LOW_FLAGS) begin
                next_state.low_flag =
                    state.low_flag & ~req.pwdata[CH-1:0];
            end else if (off == wcab_pkg::OFF_HIGH_FLAGS) begin
                next_state.high_flag =
                    state.high_flag & ~req.pwdata[CH-1:0];
            end
        end

        // Set after clear, so a hit in the clearing cycle survives
        next_state.low_flag  = next_state.low_flag | low_hit;
        next_state.high_flag = next_state.high_flag | high_hit;

        if (launch) begin
            next_state.first_trigger_channel = wcab_pkg::CHAN_ID_0;
            next_state.trig_seen = 1'b0;
            next_state.cap       = wcab_pkg::CAP_ARMED;
            next_state.ptr       = '0;
        end else begin
            if (trigger) begin
                next_state.trig_seen = 1'b1;
                // Later hits leave the recorded channel untouched
                next_state.first_trigger_channel = smp.chan
                    ? wcab_pkg::CHAN_ID_1
                    : wcab_pkg::CHAN_ID_0;
            end
            if (buf_we) begin
                next_state.ptr = state.ptr + 1'b1;
            end
            unique case (state.cap)
                wcab_pkg::CAP_ARMED: begin
                    if (smp.valid && trigger) begin
                        next_state.cap =
                            (state.mode == wcab_pkg::MODE_BEFORE)
                            ? wcab_pkg::CAP_DONE
                            : wcab_pkg::CAP_FILL;
                        if (state.mode == wcab_pkg::MODE_AFTER) begin
                            next_state.ptr = PTR_W'(1);
                        end
                    end
                end
                wcab_pkg::CAP_FILL: begin
                    if (smp.valid && state.ptr == PTR_W'(BUF_DEPTH - 1)) begin
                        next_state.cap = wcab_pkg::CAP_DONE;
                    end
                end
                wcab_pkg::CAP_DONE: next_state.cap = wcab_pkg::CAP_DONE;
                default: next_state.cap = wcab_pkg::CAP_ARMED;
            endcase
        end

        // Pin pulled low while any latched flag stands
        next_state.alert_n_oe =
            |{next_state.low_flag, next_state.high_flag};
        next_state.alert_n_out = 1'b0;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= '0;
            state.hi_thr <= {CH{wcab_pkg::HIGH_THR_RESET}};
            state.lo_thr <= {CH{wcab_pkg::LOW_THR_RESET}};
            state.limit  <= wcab_pkg::LIMIT_RESET;
            state.mode   <= wcab_pkg::MODE_BEFORE;
            state.cap    <= wcab_pkg::CAP_ARMED;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign prdata      = state.prdata;
    assign pready      = state.pready;
    assign pslverr     = state.pslverr;
    assign alert_n_out = state.alert_n_out;
    assign alert_n_oe  = state.alert_n_oe;
endmodule

/* File: verification/wcab_checker.sv */
// Checker of bus timing and alert pin
`timescale 1ns/10ps
module wcab_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_valid,
    input wire logic        alert_n_out,
    input wire logic        alert_n_oe
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic acc;
    logic flag_wr;
    assign acc = psel && penable;
    assign flag_wr = acc && pready && pwrite &&
        (paddr == wcab_pkg::OFF_LOW_FLAGS ||
         paddr == wcab_pkg::OFF_HIGH_FLAGS);

    AST_ONE_WAIT: assert property (acc && !pready |=> pready)
        else $error("late ready");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("long ready");
    AST_READY_IN_ACCESS: assert property (pready |-> acc)
        else $error("stray ready");
    AST_ERR_DATA: assert property (pslverr && !pwrite |-> pready &&
        prdata == 32'h0)
        else $error("error data");
    AST_MISALIGNED: assert property (acc && pready && paddr[1:0] != 2'h0
        |-> pslverr)
        else $error("misaligned taken");
    AST_OPEN_DRAIN: assert property (!alert_n_out)
        else $error("pin high");
    AST_ALERT_CAUSE: assert property ($rose(alert_n_oe) |->
        $past(sample_valid))
        else $error("alert uncaused");
    AST_ALERT_CLEAR: assert property ($fell(alert_n_oe) |->
        $past(flag_wr))
        else $error("alert dropped");
    AST_CHAN_CODE: assert property (acc && pready && !pwrite &&
        paddr == wcab_pkg::OFF_TRIG_CHAN |-> prdata[31:5] == 27'h0 &&
        prdata[3:0] == 4'h0)
        else $error("bad channel");

    COV_ALERT: cover property ($rose(alert_n_oe));
    COV_REFUSED: cover property (pslverr);
    COV_FLAG_CLEAR: cover property (flag_wr);
endmodule

/* File: verification/wcab_host_model.sv */
// Host side model: bus master task and the pulled-up alert line
`timescale 1ns/10ps
module wcab_host_model (
    input  wire logic               pclk,
    input  wire logic [31:0]        prdata,
    input  wire logic               pready,
    input  wire logic               pslverr,
    input  wire logic               alert_n_out,
    input  wire logic               alert_n_oe,
    output wcab_pkg::wcab_apb_req_t req,
    output logic                    alert_line
);
    // ****************************************
    // Alert line and bus transfers
    // ****************************************
    // Pull-up when released
    assign alert_line = alert_n_oe ? alert_n_out : 1'b1;

    initial req = '0;

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        // Released data must not look like a held value
        req.pwdata  <= ~d;
        @(posedge pclk);
    endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench of the window comparator block
`timescale 1ns/10ps
module testbench;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic                    pclk;
    logic                    presetn;
    logic                    sample_valid;
    logic                    sample_chan;
    logic [11:0]             sample_data;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    alert_n_out;
    logic                    alert_n_oe;
    logic                    alert_line;
    wcab_pkg::wcab_apb_req_t req;
    logic [31:0]             rd;
    logic                    er;
    logic [11:0]             hist[$];
    int                      num_errors;
    int                      checks_done;
    int                      cycles = 0;

    wcab_top wcab_top_i (.pclk, .presetn, .ce(1'b1), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
        .pwdata(req.pwdata), .prdata, .pready, .pslverr, .sample_valid,
        .sample_chan, .sample_data, .alert_n_out, .alert_n_oe);
    wcab_host_model wcab_host_model_i (.pclk, .prdata, .pready,
        .pslverr, .alert_n_out, .alert_n_oe, .req, .alert_line);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Run takes about 400 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wcab_host_model_i.xfer(1'b1, a, d, rd, er);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        wcab_host_model_i.xfer(1'b0, a, 32'h0, rd, er);
        chk(what, rd, exp);
    endtask

    task automatic thr(input logic ch, input logic [11:0] hi, lo);
        logic [7:0] b;
        b = wcab_pkg::OFF_THR_BASE + {3'b000, ch, 4'h0};
        wr(b, {24'h0, hi[7:0]});
        wr(b + 8'h04, {28'h0, hi[11:8]});
        wr(b + 8'h08, {24'h0, lo[7:0]});
        wr(b + 8'h0c, {28'h0, lo[11:8]});
    endtask

    task automatic send(input logic ch, input logic [11:0] d, input int n);
        repeat (n) begin
            sample_valid <= 1'b1;
            sample_chan  <= ch;
            sample_data  <= d;
            hist.push_back(d);
            @(posedge pclk);
        end
        sample_valid <= 1'b0;
        sample_data  <= ~d;
        @(posedge pclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        for (int c = 0; c < 2; c++) begin
            rdchk("high lsb", 8'h20 + 8'(16 * c), 32'hff);
            rdchk("high msb", 8'h24 + 8'(16 * c), 32'hf);
            rdchk("low lsb", 8'h28 + 8'(16 * c), 32'h0);
            rdchk("low msb", 8'h2c + 8'(16 * c), 32'h0);
        end
        rdchk("low flags", wcab_pkg::OFF_LOW_FLAGS, 32'h0);
        rdchk("chan", wcab_pkg::OFF_TRIG_CHAN, 32'h0);
        rdchk("unmapped", 8'h14, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        wr(8'h05, 32'h1);
        chk("misaligned err", {31'h0, er}, 32'h1);
        chk("idle alert", {31'h0, alert_line}, 32'h1);
    endtask

    task automatic t_before();
        int n;
        hist.delete();
        thr(1'b0, 12'he00, 12'h100);
        wr(wcab_pkg::OFF_CTRL, 32'h20);
        for (int i = 0; i < 20; i++)
            send(1'b0, 12'h200 + 12'(i), 1);
        send(1'b0, 12'h100, 2);
        send(1'b0, 12'h500, 1);
        send(1'b0, 12'h100, 2);
        rdchk("held off", wcab_pkg::OFF_LOW_FLAGS, 32'h0);
        send(1'b0, 12'h100, 1);
        n = hist.size();
        rdchk("low hit", wcab_pkg::OFF_LOW_FLAGS, 32'h1);
        chk("alert", {31'h0, alert_line}, 32'h0);
        send(1'b0, 12'he00, 3);
        rdchk("high hit", wcab_pkg::OFF_HIGH_FLAGS, 32'h1);
        send(1'b1, 12'hffe, 3);
        rdchk("below full", wcab_pkg::OFF_HIGH_FLAGS, 32'h1);
        send(1'b1, 12'hfff, 3);
        rdchk("full", wcab_pkg::OFF_HIGH_FLAGS, 32'h3);
        send(1'b1, 12'h001, 3);
        rdchk("above zero", wcab_pkg::OFF_LOW_FLAGS, 32'h1);
        send(1'b1, 12'h000, 3);
        rdchk("zero", wcab_pkg::OFF_LOW_FLAGS, 32'h3);
        rdchk("chan kept", wcab_pkg::OFF_TRIG_CHAN, 32'h0);
        wr(wcab_pkg::OFF_CTRL, 32'h20);
        rdchk("state", wcab_pkg::OFF_STATUS, 32'ha0f);
        for (int i = 0; i < 16; i++)
            rdchk("pre buf", wcab_pkg::OFF_BUF_BASE + 8'(4 * i),
                  {20'h0, hist[n - 16 + i]});
    endtask

    task automatic t_flags();
        wr(wcab_pkg::OFF_LOW_FLAGS, 32'h1);
        rdchk("one cleared", wcab_pkg::OFF_LOW_FLAGS, 32'h2);
        wr(wcab_pkg::OFF_LOW_FLAGS, 32'hff);
        rdchk("all cleared", wcab_pkg::OFF_LOW_FLAGS, 32'h0);
        chk("alert held", {31'h0, alert_line}, 32'h0);
        wr(wcab_pkg::OFF_HIGH_FLAGS, 32'hff);
        rdchk("high cleared", wcab_pkg::OFF_HIGH_FLAGS, 32'h0);
        chk("alert gone", {31'h0, alert_line}, 32'h1);
    endtask

    task automatic t_after();
        logic [11:0] e;
        wr(wcab_pkg::OFF_CTRL, 32'h101);
        rdchk("chan launch", wcab_pkg::OFF_TRIG_CHAN, 32'h0);
        send(1'b1, 12'h200, 5);
        send(1'b1, 12'h000, 1);
        for (int i = 0; i < 20; i++)
            send(1'b1, 12'h500 + 12'(i), 1);
        rdchk("chan one", wcab_pkg::OFF_TRIG_CHAN, 32'h10);
        rdchk("done", wcab_pkg::OFF_STATUS, 32'hf);
        for (int i = 0; i < 16; i++) begin
            e = (i == 0) ? 12'h000 : 12'h500 + 12'(i - 1);
            rdchk("post buf", wcab_pkg::OFF_BUF_BASE + 8'(4 * i),
                  {20'h0, e});
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        presetn      = 1'b0;
        sample_valid = 1'b0;
        sample_chan  = 1'b0;
        sample_data  = 12'h000;
        num_errors   = 0;
        checks_done  = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_before();
        t_flags();
        t_after();
        give_verdict();
    end
endmodule

bind wcab_top wcab_checker wcab_checker_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sample_valid,
    .alert_n_out, .alert_n_oe);
